// file: verilog/sac_map.svh
// sac_map.svh: register indices, bit positions, reset values and counts
// of the conversion controller; byte address is four times the index
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

`define SAC_IDX_FLAGS   8'h0c
`define SAC_IDX_CTRL    8'h1f
`define SAC_IDX_ANALOG_SELECT_REG   8'h20
`define SAC_IDX_RESH    8'h21
`define SAC_IDX_RESL    8'h22
`define SAC_IDX_IEN     8'h23

`define SAC_CTRL_ON     0
`define SAC_CTRL_GO     1
`define SAC_CTRL_CHS    2
`define SAC_CTRL_REF    6
`define SAC_CTRL_JUST   7
`define SAC_ANALOG_SELECT_REG_CS    4
`define SAC_FLAG_DONE   6

`define SAC_ANS_RST     4'hf
`define SAC_CS_RST      3'h0

`define SAC_CONV_TADS   4'hb
`define SAC_ABORT_TADS  4'h2
`define SAC_SAR_TOP     10'h200

`endif

// file: verilog/sac_pkg.sv
// sac_pkg: types shared by the conversion controller and its bench
// assumes sac_map.svh holds the numeric constants
package sac_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [31:0] dat;
  } sac_wb_req_type;

  typedef struct packed {
    logic [1:0]  chan;
    logic        ref_ext;
    logic        conv_en;
    logic        sample;
    logic [9:0]  dac;
  } sac_ana_type;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'h0,
    SAC_CONV = 2'h1,
    SAC_HOLD = 2'h3
  } sac_state_type;

endpackage : sac_pkg

// file: verilog/sac_conv_ctrl.sv
// sac_conv_ctrl: 10-bit successive-approximation conversion control
// assumes a classic wishbone master and a comparator synchronous to clk_i
//
// Function
// - conversion takes exactly eleven conversion clock periods
// - clock source from select field bits 6:4
// - select decodes six core dividers or RC clock
// - writing go and on bits one while already on and idle starts a conversion
// - finish clears go, sets done flag, interrupt
// - clearing go mid-conversion aborts it at once
// - abort leaves both result registers unchanged
// - after abort delay, acquisition restarts on channel
// - justify bit selects right or left result
// - reference bit selects external pin or supply
// - channel field bits 3:2 picks one input
// - each result stored as ten bits, two registers
`timescale 1ns/10ps
`default_nettype none
`include "sac_map.svh"

module sac_conv_ctrl (
  // system
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // register bus
  input  wire sac_pkg::sac_wb_req_type wb_req_i,
  output logic                         wb_ack_o,
  output logic [31:0]                  wb_dat_o,
  // converter side
  input  wire logic                    comp_i,
  input  wire logic                    rc_tick_i,
  output sac_pkg::sac_ana_type         ana_o,
  output logic                         irq_o
);
  import sac_pkg::*;

  logic          on_q;
  logic          go_q;
  logic [1:0]    chan_q;
  logic          ref_q;
  logic          just_q;
  logic [2:0]    cs_q;
  logic [3:0]    ans_q;
  logic          done_q;
  logic          ien_q;
  logic [9:0]    result_q;
  logic [9:0]    sar_q;
  logic [9:0]    sar_d;
  logic [3:0]    tad_q;
  logic [5:0]    div_q;
  sac_state_type state_q;
  logic          acc;
  logic          wr;
  logic [7:0]    idx;
  logic [7:0]    wdat;
  logic          wr_ctrl;
  logic          tick;
  logic          start;
  logic          abort;
  logic          finish;

  // divider terminal count per select code, zero for the rc source
  function automatic logic [5:0] div_limit(input logic [2:0] cs);
    case (cs)
      3'h0:    div_limit = 6'h01;
      3'h4:    div_limit = 6'h03;
      3'h1:    div_limit = 6'h07;
      3'h5:    div_limit = 6'h0f;
      3'h2:    div_limit = 6'h1f;
      3'h6:    div_limit = 6'h3f;
      default: div_limit = 6'h00;
    endcase
  endfunction : div_limit

  function automatic logic is_rc(input logic [2:0] cs);
    is_rc = (cs[1:0] == 2'h3);
  endfunction : is_rc

  // read view of each mapped index
  function automatic logic [7:0] rd_reg(input logic [7:0] i);
    case (i)
      `SAC_IDX_CTRL:  rd_reg = {just_q, ref_q, 2'h0, chan_q, go_q, on_q};
      `SAC_IDX_ANALOG_SELECT_REG: rd_reg = {1'h0, cs_q, ans_q};
      `SAC_IDX_FLAGS: rd_reg = {1'h0, done_q, 6'h00};
      `SAC_IDX_IEN:   rd_reg = {1'h0, ien_q, 6'h00};
      `SAC_IDX_RESH:  rd_reg = just_q ? {6'h00, result_q[9:8]}
                                      : result_q[9:2];
      `SAC_IDX_RESL:  rd_reg = just_q ? result_q[7:0]
                                      : {result_q[1:0], 6'h00};
      default:        rd_reg = 8'h00;
    endcase
  endfunction : rd_reg

  assign acc     = ce_i & wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign wr      = acc & wb_req_i.we & wb_req_i.sel[0];
  assign idx     = wb_req_i.adr[9:2];
  assign wdat    = wb_req_i.dat[7:0];
  assign wr_ctrl = wr & (idx == `SAC_IDX_CTRL);

  // conversion clock tick
  assign tick = is_rc(cs_q) ? rc_tick_i : (div_q == div_limit(cs_q));

  assign start  = wr_ctrl & wdat[`SAC_CTRL_GO] & wdat[`SAC_CTRL_ON] & on_q
                & ~go_q & (state_q == SAC_IDLE);
  assign abort  = wr_ctrl & (state_q == SAC_CONV)
                & ~(wdat[`SAC_CTRL_GO] & wdat[`SAC_CTRL_ON]);
  assign finish = (state_q == SAC_CONV) & tick & ~abort
                & (tad_q == `SAC_CONV_TADS - 4'h1);

  // bit under trial resolves from the comparator, next bit is tried
  always_comb
  begin
    sar_d = sar_q;
    for (int i = 0; i < 10; i++)
    begin
      if (tad_q != 4'h0 && 4'(i) == 4'h0a - tad_q)
        sar_d[i] = comp_i;
      else if (tad_q != 4'h0 && 4'(i) + 4'h1 == 4'h0a - tad_q)
        sar_d[i] = 1'b1;
    end
  end

  // bus handshake
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= acc;
      if (acc)
        wb_dat_o <= {24'h00_0000, rd_reg(idx)};
    end
  end

  // control and select fields
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      on_q   <= 1'b0;
      chan_q <= 2'h0;
      ref_q  <= 1'b0;
      just_q <= 1'b0;
      cs_q   <= `SAC_CS_RST;
      ans_q  <= `SAC_ANS_RST;
      ien_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
      begin
        on_q   <= wdat[`SAC_CTRL_ON];
        chan_q <= wdat[`SAC_CTRL_CHS +: 2];
        ref_q  <= wdat[`SAC_CTRL_REF];
        just_q <= wdat[`SAC_CTRL_JUST];
      end
      if (wr & (idx == `SAC_IDX_ANALOG_SELECT_REG))
      begin
        cs_q  <= wdat[`SAC_ANALOG_SELECT_REG_CS +: 3];
        ans_q <= wdat[3:0];
      end
      if (wr & (idx == `SAC_IDX_IEN))
        ien_q <= wdat[`SAC_FLAG_DONE];
    end
  end

  // go flag: cleared by hardware at finish, abort or power-off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      go_q <= 1'b0;
    else if (ce_i)
    begin
      if (finish | ~on_q)
        go_q <= 1'b0;
      else if (wr_ctrl)
        go_q <= (go_q | start) & wdat[`SAC_CTRL_GO] & wdat[`SAC_CTRL_ON];
    end
  end

  // done flag and interrupt; a finish wins over a software clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_q <= 1'b0;
      irq_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (finish)
        done_q <= 1'b1;
      else if (wr & (idx == `SAC_IDX_FLAGS))
        done_q <= wdat[`SAC_FLAG_DONE];
      irq_o <= done_q & ien_q;
    end
  end

  // conversion clock divider, restarted with each conversion
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_q <= 6'h00;
    else if (ce_i)
    begin
      if (start | tick | abort | (state_q == SAC_IDLE))
        div_q <= 6'h00;
      else
        div_q <= div_q + 6'h01;
    end
  end

  // sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= SAC_IDLE;
      tad_q   <= 4'h0;
      sar_q   <= 10'h000;
    end
    else if (ce_i)
    begin
      if (~on_q)
        state_q <= SAC_IDLE;
      else
        case (state_q)
          SAC_IDLE:
          begin
            if (start)
            begin
              state_q <= SAC_CONV;
              tad_q   <= 4'h0;
              sar_q   <= `SAC_SAR_TOP;
            end
          end
          SAC_CONV:
          begin
            if (abort)
            begin
              state_q <= SAC_HOLD;
              tad_q   <= 4'h0;
            end
            else if (tick)
            begin
              sar_q <= sar_d;
              tad_q <= tad_q + 4'h1;
              if (finish)
                state_q <= SAC_IDLE;
            end
          end
          SAC_HOLD:
          begin
            if (tick)
            begin
              tad_q <= tad_q + 4'h1;
              if (tad_q == `SAC_ABORT_TADS - 4'h1)
                state_q <= SAC_IDLE;
            end
          end
          default:
            state_q <= SAC_IDLE;
        endcase
    end
  end

  // result written only by a completed conversion
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result_q <= 10'h000;
    else if (ce_i & finish)
      result_q <= sar_d;
  end

  // converter drive; idle with converter on means acquiring
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ana_o <= '0;
    else if (ce_i)
    begin
      ana_o.chan    <= chan_q;
      ana_o.ref_ext <= ref_q;
      ana_o.conv_en <= on_q;
      ana_o.sample  <= on_q & (state_q == SAC_IDLE);
      ana_o.dac     <= sar_q;
    end
  end

  // checks
  logic [3:0] ticks_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ticks_q <= 4'h0;
    else if (ce_i)
    begin
      if (start)
        ticks_q <= 4'h0;
      else if (tick & (state_q == SAC_CONV))
        ticks_q <= ticks_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_finish;
    ce_i && finish;
  endsequence

  property p_conv_len;
    s_finish |-> ticks_q == 4'ha;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length is not eleven periods");

  property p_div_space;
    (ce_i && tick && !is_rc(cs_q) && state_q == SAC_CONV) |=> !tick;
  endproperty
  a_div_space: assert property (p_div_space)
    else $error("divided conversion clock ticked twice in a row");

  property p_start;
    (ce_i && start) |=> state_q == SAC_CONV && go_q && sar_q == 10'h200;
  endproperty
  a_start: assert property (p_start)
    else $error("go write did not start a conversion");

  property p_done;
    s_finish |=> !go_q && done_q && state_q == SAC_IDLE ##1 (irq_o == ien_q);
  endproperty
  a_done: assert property (p_done)
    else $error("finish did not clear go and set done");

  property p_abort;
    (ce_i && abort && on_q) |=> state_q == SAC_HOLD && !go_q && $stable(result_q);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort changed the result or did not stop");

  property p_release;
    (ce_i && on_q && state_q == SAC_HOLD && tick && tad_q == 4'h1)
      |=> state_q == SAC_IDLE ##1 ana_o.sample;
  endproperty
  a_release: assert property (p_release)
    else $error("acquisition did not restart after abort delay");

  property p_just;
    (acc && !wb_req_i.we && idx == `SAC_IDX_RESH && just_q)
      |=> wb_ack_o && wb_dat_o[7:2] == 6'h00;
  endproperty
  a_just: assert property (p_just)
    else $error("right justified high byte has upper bits set");

  property p_off;
    (ce_i && !on_q) |=> state_q == SAC_IDLE && !go_q;
  endproperty
  a_off: assert property (p_off)
    else $error("converter ran while switched off");

  property p_unimpl;
    (acc && idx == `SAC_IDX_CTRL) |=> wb_dat_o[5:4] == 2'h0;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented control bits read nonzero");

endmodule : sac_conv_ctrl

`default_nettype wire

// file: verification/sar_adc_conversion_control_bench.sv
// sar_adc_conversion_control_bench: self-checking bench of sac_conv_ctrl
// assumes sac_pkg and sac_map.svh compiled first; comparator modelled from a target code
`timescale 1ns/10ps
`default_nettype none
`include "sac_map.svh"

module sar_adc_conversion_control_bench;
  import sac_pkg::*;
  logic           clk_i;
  logic           rst_i;
  logic           ce_i;
  sac_wb_req_type wb_req_i;
  logic           wb_ack_o;
  logic [31:0]    wb_dat_o;
  wire logic      comp_i;
  logic           rc_tick_i = 1'b0;
  sac_ana_type    ana_o;
  logic           irq_o;
  int             num_errors;
  int             cmp_count;
  int             seed;
  logic           rc_run;
  logic [2:0]     rc_cnt = 3'h0;
  logic [9:0]     target;
  logic [9:0]     last_res;
  logic [31:0]    rd;
  int             divs[8] = '{2, 8, 32, 0, 4, 16, 64, 0};

  sac_conv_ctrl uut (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .wb_req_i  (wb_req_i),
    .wb_ack_o  (wb_ack_o),
    .wb_dat_o  (wb_dat_o),
    .comp_i    (comp_i),
    .rc_tick_i (rc_tick_i),
    .ana_o     (ana_o),
    .irq_o     (irq_o)
  );

  always #2.5 clk_i = ~clk_i;

  // ideal comparator settles within a core cycle, so every source is slow enough
  assign comp_i = (ana_o.dac <= target);

  // internal rc clock model, one pulse every eight core cycles, as in a sleeping core
  always @(posedge clk_i)
  begin
    rc_cnt    <= rc_cnt + 3'h1;
    rc_tick_i <= rc_run && (rc_cnt == 3'h7);
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one classic cycle; request held until ack is sampled high at a rising edge
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wdat,
                         output logic [31:0] rdat);
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {idx, 2'b00},
                  dat: {24'h0, wdat}};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_req_i <= '0;
  endtask : wb_xfer

  task automatic read_res(input logic [7:0] ctl);
    logic [31:0] hi;
    logic [31:0] lo;
    for (int j = 0; j < 2; j++)
    begin
      wb_xfer(1'b1, `SAC_IDX_CTRL, {j[0], ctl[6:0]}, rd);
      wb_xfer(1'b0, `SAC_IDX_RESH, 8'h00, hi);
      wb_xfer(1'b0, `SAC_IDX_RESL, 8'h00, lo);
      check("result_high", j ? {30'h0, last_res[9:8]} : {24'h0, last_res[9:2]}, hi);
      check("result_low", j ? {24'h0, last_res[7:0]} : {24'h0, last_res[1:0], 6'h0}, lo);
    end
  endtask : read_res

  task automatic convert(input logic [2:0] cs);
    logic [7:0] ctl;
    int         n;
    int         p;
    int         k;
    ctl = {1'b0, 1'($random(seed)), 2'b00, 2'($random(seed)), 2'b01};
    target = 10'($random(seed));
    n = 0;
    p = 0;
    wb_xfer(1'b1, `SAC_IDX_ANALOG_SELECT_REG, {1'b0, cs, 4'hf}, rd);
    wb_xfer(1'b1, `SAC_IDX_CTRL, ctl | 8'h30, rd);
    wb_xfer(1'b0, `SAC_IDX_CTRL, 8'h00, rd);
    check("control", {24'h0, ctl}, rd);
    check("channel", {30'h0, ctl[3:2]}, {30'h0, ana_o.chan});
    check("reference", {30'h0, ctl[6], 1'b1}, {30'h0, ana_o.ref_ext, ana_o.conv_en});
    wb_xfer(1'b1, `SAC_IDX_CTRL, ctl | 8'h02, rd);
    rc_run <= (cs[1:0] == 2'b11);
    k = 0;
    forever
    begin
      @(negedge clk_i);
      if (irq_o === 1'b1 || n > 2000)
        break;
      n++;
      p += int'(rc_tick_i === 1'b1);
      k += int'(ce_i === 1'b0);
      @(posedge clk_i);
      // random pauses stay well before the last period; each one delays the finish by a cycle
      ce_i <= (n >= 8 * divs[cs]) || ($random(seed) % 4 != 0);
    end
    rc_run <= 1'b0;
    if (cs[1:0] == 2'b11)
      check("rc ticks", 11, p);
    else
      check("conv cycles", 11 * divs[cs] + k, n);
    last_res = target;
    wb_xfer(1'b0, `SAC_IDX_CTRL, 8'h00, rd);
    check("go", 32'h0, {31'h0, rd[1]});
    wb_xfer(1'b0, `SAC_IDX_FLAGS, 8'h00, rd);
    check("done", 32'h40, rd & 32'h40);
    read_res(ctl);
    wb_xfer(1'b1, `SAC_IDX_FLAGS, 8'h00, rd);
    @(negedge clk_i);
    check("irq", 32'h0, {31'h0, irq_o});
  endtask : convert

  initial
  begin
    #100000;
    num_errors++;
    close_out();
  end

  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_req_i = '0;
    rc_run = 1'b0;
    target = 10'h0;
    last_res = 10'h0;
    seed = 73;
    num_errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, `SAC_IDX_CTRL, 8'h00, rd);
    check("control reset", 32'h0, rd);
    wb_xfer(1'b0, `SAC_IDX_ANALOG_SELECT_REG, 8'h00, rd);
    check("select reset", 32'h0f, rd);
    wb_xfer(1'b1, 8'h50, 8'hff, rd);
    wb_xfer(1'b0, 8'h50, 8'h00, rd);
    check("unmapped", 32'h0, rd);
    wb_xfer(1'b1, `SAC_IDX_CTRL, 8'h02, rd);
    wb_xfer(1'b0, `SAC_IDX_CTRL, 8'h00, rd);
    check("go while off", 32'h0, rd);
    check("converter off", 32'h0, {31'h0, ana_o.conv_en});
    wb_xfer(1'b1, `SAC_IDX_IEN, 8'h40, rd);
    for (int c = 0; c < 8; c++)
      convert(c[2:0]);
    // abort a slow conversion part way, then try to restart inside the holdoff
    target = 10'($random(seed));
    wb_xfer(1'b1, `SAC_IDX_ANALOG_SELECT_REG, 8'h60, rd);
    wb_xfer(1'b1, `SAC_IDX_CTRL, 8'h03, rd);
    repeat (20) @(posedge clk_i);
    wb_xfer(1'b1, `SAC_IDX_CTRL, 8'h01, rd);
    wb_xfer(1'b1, `SAC_IDX_CTRL, 8'h03, rd);
    wb_xfer(1'b0, `SAC_IDX_CTRL, 8'h00, rd);
    @(negedge clk_i);
    check("go after abort", 32'h01, rd);
    check("acquire in holdoff", 32'h0, {31'h0, ana_o.sample});
    wb_xfer(1'b0, `SAC_IDX_FLAGS, 8'h00, rd);
    check("no done", 32'h0, rd);
    repeat (130) @(negedge clk_i);
    check("acquire", 32'h1, {31'h0, ana_o.sample});
    read_res(8'h01);
    close_out();
  end
endmodule : sar_adc_conversion_control_bench

`default_nettype wire
